// ---- pkg/ddr2_dev_defs.vh ----
// register offsets, field positions, reset values and command codes of the ddr2 device model
`ifndef DDR2_DEV_DEFS_VH
`define DDR2_DEV_DEFS_VH

// register offsets (byte addresses)
`define REG_CFG 8'h00
`define REG_STATUS 8'h04
`define REG_REFCNT 8'h08
`define REG_CAPT 8'h0C
`define REG_LOCKCNT 8'h10

// configuration fields
`define CFG_RAS_LSB 0
`define CFG_RAS_MSB 4
`define CFG_RDAP_LSB 5
`define CFG_RDAP_MSB 9
`define CFG_WRAP_LSB 10
`define CFG_WRAP_MSB 14
`define CFG_WID_LSB 15
`define CFG_WID_MSB 16

// configuration reset value: min row active 6, read ap delay 2, write ap delay 8, x16
`define CFG_RESET 32'h00012046

// data width modes
`define WID_X4 2'h0
`define WID_X8 2'h1
`define WID_X16 2'h2

// command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_ACT 4'h3
`define CMD_RD 4'h5
`define CMD_WR 4'h4
`define CMD_PRE 4'h2
`define CMD_REF 4'h1

`endif

// ---- src/ddr2_bank_timer.v ----
// one bank: open state, row-active timer and auto-precharge with row-active lockout
`timescale 1ns/1ps
module ddr2_bank_timer #(
  parameter CW = 5
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // link clock rising edge and commands aimed at this bank
  input wire i_tick,
  input wire i_act,
  input wire i_cas_ap,
  input wire i_is_wr,
  input wire i_pre,
  // configuration in link clocks
  input wire [CW-1:0] i_ras_min,
  input wire [CW-1:0] i_rd_dly,
  input wire [CW-1:0] i_wr_dly,
  // state
  output wire o_open,
  output wire o_pend,
  output wire o_held
);
  reg open_q;
  reg pend_q;
  reg [CW-1:0] ras_cnt_q;
  reg [CW-1:0] dly_q;
  wire ras_met;

  assign ras_met = (ras_cnt_q >= i_ras_min);
  assign o_open = open_q;
  assign o_pend = pend_q;
  // internal precharge due but row not yet active long enough
  assign o_held = pend_q && (dly_q == {CW{1'b0}}) && !ras_met;

  // bank state; commands only arrive together with a tick
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      open_q <= 1'b0;
      pend_q <= 1'b0;
      ras_cnt_q <= {CW{1'b0}};
      dly_q <= {CW{1'b0}};
    end else if (i_tick) begin
      if (open_q && !ras_met)
        ras_cnt_q <= ras_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      if (i_act) begin
        open_q <= 1'b1;
        pend_q <= 1'b0;
        ras_cnt_q <= {CW{1'b0}};
      end else if (i_pre) begin
        open_q <= 1'b0;
        pend_q <= 1'b0;
      end else if (i_cas_ap && open_q) begin
        // accepted even though the row-active time may not be met yet
        pend_q <= 1'b1;
        dly_q <= i_is_wr ? i_wr_dly : i_rd_dly;
      end else if (pend_q) begin
        if (dly_q != {CW{1'b0}})
          dly_q <= dly_q - {{(CW-1){1'b0}}, 1'b1};
        else if (ras_met) begin
          // precharge only once the row-active minimum is satisfied
          open_q <= 1'b0;
          pend_q <= 1'b0;
        end
      end
    end
  end
endmodule // ddr2_bank_timer

// ---- src/ddr2_dev_core.v ----
// ddr2 device command logic: bank state, auto-precharge lockout, refresh and strobe capture
//
// How it works
// - auto-precharge accepted before row-active time met
// - internal precharge held until row-active time met
// - back-to-back refreshes accepted, no interval maximum
// - each strobe captures only its own data group
`timescale 1ns/1ps
`include "ddr2_dev_defs.vh"
module ddr2_dev_core #(
  parameter NB = 8,
  parameter CW = 5,
  parameter DW = 16
) (
  // system clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata_q,
  // memory pins from the controller
  input wire i_ck,
  input wire i_cke,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [2:0] i_ba,
  input wire i_a10,
  input wire [DW-1:0] i_dq,
  input wire i_lower_byte_strobe,
  input wire i_upper_byte_strobe,
  // device state
  output reg [NB-1:0] o_bank_open_q,
  output reg o_ap_hold_q,
  output reg [DW-1:0] o_capt_data_q
);
  // two-stage synchronisers plus a third stage for edge detection
  reg [1:0] ck_s_q;
  reg ck_d_q;
  reg [1:0] cke_s_q;
  reg [3:0] cmd_s1_q;
  reg [3:0] cmd_s2_q;
  reg [2:0] ba_s1_q;
  reg [2:0] ba_s2_q;
  reg [1:0] a10_s_q;
  reg [DW-1:0] dq_s1_q;
  reg [DW-1:0] dq_s2_q;
  reg [1:0] lqs_s_q;
  reg [1:0] uqs_s_q;
  reg lqs_d_q;
  reg uqs_d_q;

  // software-visible registers
  reg [31:0] cfg_q;
  reg [31:0] refcnt_q;
  reg [31:0] lockcnt_q;

  wire tick;
  wire [3:0] cmd;
  wire cmd_act;
  wire cmd_rd;
  wire cmd_wr;
  wire cmd_pre;
  wire cmd_ref;
  wire lqs_edge;
  wire uqs_edge;
  wire [1:0] wid;
  wire [NB-1:0] bank_open;
  wire [NB-1:0] bank_pend;
  wire [NB-1:0] bank_held;
  wire [NB-1:0] bank_sel;
  wire any_held;
  // decoded configuration fields and bus words
  wire cmd_ok;
  wire [CW-1:0] ras_min;
  wire [CW-1:0] rd_ap_dly;
  wire [CW-1:0] wr_ap_dly;
  wire [31:0] status_word;
  reg [31:0] cfg_d;
  reg [31:0] rdata_d;

  // link clock and clock enable; the second stage and the clock's third (edge) stage feed the logic
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ck_s_q <= 2'h0;
      ck_d_q <= 1'b0;
      cke_s_q <= 2'h0;
    end else begin
      ck_s_q <= {ck_s_q[0], i_ck};
      ck_d_q <= ck_s_q[1];
      cke_s_q <= {cke_s_q[0], i_cke};
    end
  end

  // command and address pins; idle command after reset so no false decode appears
  // the controller holds them for a whole link clock, so all bits settle together
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      cmd_s1_q <= 4'hF;
      cmd_s2_q <= 4'hF;
      ba_s1_q <= 3'h0;
      ba_s2_q <= 3'h0;
      a10_s_q <= 2'h0;
    end else begin
      cmd_s1_q <= {i_cs_n, i_ras_n, i_cas_n, i_we_n};
      cmd_s2_q <= cmd_s1_q;
      ba_s1_q <= i_ba;
      ba_s2_q <= ba_s1_q;
      a10_s_q <= {a10_s_q[0], i_a10};
    end
  end

  // data pins; the data sit in the second stage when the strobe edge is seen
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      dq_s1_q <= {DW{1'b0}};
      dq_s2_q <= {DW{1'b0}};
    end else begin
      dq_s1_q <= i_dq;
      dq_s2_q <= dq_s1_q;
    end
  end

  // strobes plus a third stage for detecting both edges
  // reset value matches the low idle level of the strobes, so no false edge follows reset
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      lqs_s_q <= 2'h0;
      uqs_s_q <= 2'h0;
      lqs_d_q <= 1'b0;
      uqs_d_q <= 1'b0;
    end else begin
      lqs_s_q <= {lqs_s_q[0], i_lower_byte_strobe};
      uqs_s_q <= {uqs_s_q[0], i_upper_byte_strobe};
      lqs_d_q <= lqs_s_q[1];
      uqs_d_q <= uqs_s_q[1];
    end
  end

  // link clock rising edge; commands count only while clock enable is high
  // a stopped link clock gives no tick, so bank state freezes with it
  assign tick = ck_s_q[1] && !ck_d_q;
  assign cmd_ok = tick && cke_s_q[1];
  assign cmd = cmd_s2_q;
  assign cmd_act = cmd_ok && (cmd == `CMD_ACT);
  assign cmd_rd = cmd_ok && (cmd == `CMD_RD);
  assign cmd_wr = cmd_ok && (cmd == `CMD_WR);
  assign cmd_pre = cmd_ok && (cmd == `CMD_PRE);
  assign cmd_ref = cmd_ok && (cmd == `CMD_REF);

  // timing fields in link clocks, written by software to match the part in use
  assign ras_min = cfg_q[`CFG_RAS_MSB:`CFG_RAS_LSB];
  assign rd_ap_dly = cfg_q[`CFG_RDAP_MSB:`CFG_RDAP_LSB];
  assign wr_ap_dly = cfg_q[`CFG_WRAP_MSB:`CFG_WRAP_LSB];
  assign wid = cfg_q[`CFG_WID_MSB:`CFG_WID_LSB];
  assign any_held = |bank_held;

  // strobes sample data on both edges, as a double data rate strobe does
  assign lqs_edge = lqs_s_q[1] ^ lqs_d_q;
  assign uqs_edge = uqs_s_q[1] ^ uqs_d_q;

  // one bank timer per bank, selected by the bank address
  // each timer keeps its own row-active count, so a lockout on one bank never
  // stalls another
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_bank
      localparam [2:0] BANK_ID = g;
      assign bank_sel[g] = (ba_s2_q == BANK_ID);
      ddr2_bank_timer #(
        .CW(CW)
      ) u_bank (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_tick(tick),
        .i_act(cmd_act && bank_sel[g]),
        .i_cas_ap((cmd_rd || cmd_wr) && a10_s_q[1] && bank_sel[g]),
        .i_is_wr(cmd_wr),
        // precharge-all closes every bank at once
        .i_pre(cmd_pre && (a10_s_q[1] || bank_sel[g])),
        .i_ras_min(ras_min),
        .i_rd_dly(rd_ap_dly),
        .i_wr_dly(wr_ap_dly),
        .o_open(bank_open[g]),
        .o_pend(bank_pend[g]),
        .o_held(bank_held[g])
      );
    end
  endgenerate

  // refresh commands counted without any interval limit, so bursts are fine
  // the count simply wraps; software reads differences, not absolute values
  always @(posedge i_clk_sys) begin
    if (!i_nrst)
      refcnt_q <= 32'h00000000;
    else if (cmd_ref)
      refcnt_q <= refcnt_q + 32'h00000001;
  end

  // link clocks spent with an internal precharge held back by lockout
  // lets software see how much an early auto precharge really cost
  always @(posedge i_clk_sys) begin
    if (!i_nrst)
      lockcnt_q <= 32'h00000000;
    else if (tick && any_held)
      lockcnt_q <= lockcnt_q + 32'h00000001;
  end

  // each strobe captures only the data lines of its own group
  // the untouched group keeps its last value, so one capture never clobbers the other
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_capt_data_q <= {DW{1'b0}};
    end else begin
      if (lqs_edge) begin
        if (wid == `WID_X4)
          o_capt_data_q[3:0] <= dq_s2_q[3:0];
        else
          o_capt_data_q[7:0] <= dq_s2_q[7:0];
      end
      // the upper strobe exists only on the x16 organisation
      if (uqs_edge && (wid == `WID_X16))
        o_capt_data_q[DW-1:8] <= dq_s2_q[DW-1:8];
    end
  end

  // registered copy of the open mask for the output and the status word
  always @(posedge i_clk_sys) begin
    if (!i_nrst)
      o_bank_open_q <= {NB{1'b0}};
    else
      o_bank_open_q <= bank_open;
  end

  // registered lockout indication
  always @(posedge i_clk_sys) begin
    if (!i_nrst)
      o_ap_hold_q <= 1'b0;
    else
      o_ap_hold_q <= any_held;
  end

  // next configuration; undefined bits are dropped so they always read as zero
  // timing fields should change only while every bank is idle, since running
  // timers compare against them on every tick
  always @* begin
    cfg_d = cfg_q;
    if (i_wr && (i_addr == `REG_CFG))
      cfg_d = {15'h0000, i_wdata[`CFG_WID_MSB:0]};
  end

  // configuration register
  always @(posedge i_clk_sys) begin
    if (!i_nrst)
      cfg_q <= `CFG_RESET;
    else
      cfg_q <= cfg_d;
  end

  // status word: open mask from the registered copy, so it agrees with the open output
  assign status_word = {8'h00, bank_held, bank_pend, o_bank_open_q};

  // read data select; anything but a read cycle returns zero
  // unmapped addresses also return zero rather than a stale word
  always @* begin
    rdata_d = 32'h00000000;
    if (i_rd) begin
      if (i_addr == `REG_CFG)
        rdata_d = cfg_q;
      else if (i_addr == `REG_STATUS)
        rdata_d = status_word;
      else if (i_addr == `REG_REFCNT)
        rdata_d = refcnt_q;
      else if (i_addr == `REG_CAPT)
        rdata_d = {16'h0000, o_capt_data_q};
      else if (i_addr == `REG_LOCKCNT)
        rdata_d = lockcnt_q;
    end
  end

  // register reads: data stand only in the cycle after the strobe
  always @(posedge i_clk_sys) begin
    if (!i_nrst)
      o_rdata_q <= 32'h00000000;
    else
      o_rdata_q <= rdata_d;
  end
endmodule // ddr2_dev_core

// ---- verification/ddr2_dev_sva.sv ----
// concurrent checks on the ddr2 device command logic ports
`timescale 1ns/1ps
module ddr2_dev_sva #(
  parameter NB = 8,
  parameter DW = 16
) (
  // clock, reset and register port
  input wire i_clk_sys,
  input wire i_nrst,
  input wire [7:0] i_addr,
  input wire i_rd,
  input wire [31:0] o_rdata_q,
  // memory pins
  input wire i_ck,
  input wire i_cke,
  input wire i_lower_byte_strobe,
  input wire i_upper_byte_strobe,
  // device state
  input wire [NB-1:0] o_bank_open_q,
  input wire o_ap_hold_q,
  input wire [DW-1:0] o_capt_data_q
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // eight quiet cycles drain the two sync flops and the decode stage
  sequence strobes_quiet;
    ($stable(i_lower_byte_strobe) && $stable(i_upper_byte_strobe)) [*8];
  endsequence
  sequence ck_still;
    $stable(i_ck) [*8];
  endsequence
  a_rd_idle_zero: assert property (!$past(i_rd) |-> o_rdata_q == 32'h0)
    else $error("read data not zero outside read cycle");
  a_cfg_high_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h00
    |-> o_rdata_q[31:17] == 15'h0) else $error("config upper bits not zero");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 8'h10
    |-> o_rdata_q == 32'h0) else $error("unmapped read not zero");
  a_status_open: assert property ($past(i_rd) && $past(i_addr) == 8'h04
    |-> o_rdata_q[7:0] == $past(o_bank_open_q)) else $error("status open mismatch");
  a_held_is_open: assert property (o_ap_hold_q |-> |o_bank_open_q)
    else $error("hold without open bank");
  a_cke_low_act: assert property ((!i_cke) [*8]
    |-> (o_bank_open_q & ~$past(o_bank_open_q)) == 8'h0) else $error("bank opened with cke low");
  a_capt_quiet: assert property (strobes_quiet |=> $stable(o_capt_data_q))
    else $error("capture without strobe edge");
  a_ck_still_state: assert property (ck_still |=> $stable(o_bank_open_q))
    else $error("bank state moved without link clock");
endmodule // ddr2_dev_sva
bind ddr2_dev_core ddr2_dev_sva #(.NB(NB), .DW(DW)) u_sva (.i_clk_sys, .i_nrst, .i_addr,
  .i_rd, .o_rdata_q, .i_ck, .i_cke, .i_lower_byte_strobe, .i_upper_byte_strobe,
  .o_bank_open_q, .o_ap_hold_q, .o_capt_data_q);

// ---- verification/ddr2_ctrl_model.sv ----
// controller-side model: link clock that stops with clock enable low, commands, clock enable and strobes
`timescale 1ns/1ps
module ddr2_ctrl_model (
  // system clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // memory pins toward the device
  output reg o_ck,
  output reg o_cke,
  output reg [3:0] o_cmd,
  output reg [2:0] o_ba,
  output reg o_a10,
  output reg [15:0] o_dq,
  output reg o_ls,
  output reg o_us
);
  reg [2:0] cnt_q;
  reg [1:0] low_q;
  reg cke_want;
  // strobes start idle low, so the first edge is a rising one
  initial begin
    {o_ck, o_cke, o_ba, o_a10, o_dq, o_ls, o_us, cnt_q, low_q, cke_want} = 0;
    o_cmd = 4'hF;
  end
  // link clock of eight system cycles; cke low while reset
  // the clock stops only after three rises have registered cke low
  always @(posedge i_clk_sys) begin
    cnt_q <= cnt_q + 3'h1;
    o_ck <= cnt_q[2] & (low_q != 2'h3);
    if (cnt_q == 3'h4) begin
      if (o_cke | cke_want) low_q <= 2'h0;
      else if (low_q != 2'h3) low_q <= low_q + 2'h1;
    end
    if (cnt_q == 3'h7) o_cke <= cke_want & i_nrst;
  end
  task setcke(input v);
    cke_want = v;
  endtask
  // one idle link clock after each command
  task cmd(input [3:0] c, input [2:0] b, input a);
    @(posedge i_clk_sys iff cnt_q == 3'h7);
    o_cmd <= c;
    o_ba <= b;
    o_a10 <= a;
    @(posedge i_clk_sys iff cnt_q == 3'h7);
    o_cmd <= 4'hF;
    o_ba <= ~b;
    o_a10 <= ~a;
  endtask
  // data held around one strobe edge, then a changed pattern
  task strb(input [15:0] d, input l, input u);
    @(posedge i_clk_sys) o_dq <= d;
    repeat (2) @(posedge i_clk_sys);
    o_ls <= o_ls ^ l;
    o_us <= o_us ^ u;
    repeat (6) @(posedge i_clk_sys);
    o_dq <= ~d;
  endtask
endmodule // ddr2_ctrl_model

// ---- verification/tb_top.sv ----
// self-checking bench for the ddr2 device command logic
`timescale 1ns/1ps
`include "ddr2_dev_defs.vh"
module tb_top;
  reg i_clk_sys = 1'b0;
  reg i_nrst = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  wire [31:0] o_rdata_q;
  wire [7:0] bo;
  wire hold;
  wire [15:0] capt;
  wire ck, cke, a10, ls, us;
  wire [3:0] c;
  wire [2:0] ba;
  wire [15:0] dq;
  integer n_errors = 0;
  integer n_tests = 0;
  integer n;
  reg [31:0] v, w;
  always #20 i_clk_sys = ~i_clk_sys;
  ddr2_ctrl_model m (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .o_ck(ck), .o_cke(cke),
    .o_cmd(c), .o_ba(ba), .o_a10(a10), .o_dq(dq), .o_ls(ls), .o_us(us));
  ddr2_dev_core uut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata_q(o_rdata_q), .i_ck(ck),
    .i_cke(cke), .i_cs_n(c[3]), .i_ras_n(c[2]), .i_cas_n(c[1]), .i_we_n(c[0]), .i_ba(ba),
    .i_a10(a10), .i_dq(dq), .i_lower_byte_strobe(ls), .i_upper_byte_strobe(us),
    .o_bank_open_q(bo), .o_ap_hold_q(hold), .o_capt_data_q(capt));
  task chk(input [31:0] s, input [31:0] e, input string nm);
    n_tests = n_tests + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task idle(input integer k);
    repeat (k) @(posedge i_clk_sys);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys) i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys) i_rd <= 1'b0;
    #1 v = o_rdata_q;
  endtask
  task t_regs;
    rd(`REG_CFG); chk(v, `CFG_RESET, "cfg_reset");
    rd(8'h14); chk(v, 32'h0, "unmapped");
    wr(`REG_CFG, 32'hFFFFFFFF); rd(`REG_CFG); chk(v, 32'h0001FFFF, "cfg_rw");
    wr(`REG_STATUS, 32'hFF); rd(`REG_STATUS); chk(v, 32'h0, "status_ro");
    wr(`REG_CFG, `CFG_RESET);
  endtask
  // read delay expires before row-active time, so the close is held
  task t_lockout;
    m.setcke(1'b1); idle(24); n = 0;
    m.cmd(`CMD_ACT, 3'h0, 1'b0); m.cmd(`CMD_RD, 3'h0, 1'b1);
    while (hold !== 1'b1 && n < 300) begin idle(1); n = n + 1; end
    chk(hold, 1'b1, "ap_hold");
    chk(bo[0], 1'b1, "open_held");
    while (bo[0] !== 1'b0 && n < 600) begin idle(1); n = n + 1; end
    chk(bo, 8'h00, "ap_close");
    // read delay ends after tick 4, row-active minimum of 6 met at tick 7: two held
    rd(`REG_LOCKCNT); chk(v, 32'h2, "lock_count");
  endtask
  task t_pre;
    for (n = 1; n < 4; n = n + 1) m.cmd(`CMD_ACT, n[2:0], 1'b0);
    idle(8); chk(bo, 8'h0E, "three_open");
    m.cmd(`CMD_PRE, 3'h3, 1'b0); idle(8); chk(bo, 8'h06, "single_pre");
    m.cmd(`CMD_PRE, 3'h0, 1'b1); idle(8); chk(bo, 8'h00, "all_pre");
  endtask
  task t_refresh;
    rd(`REG_REFCNT); w = v;
    repeat (4) m.cmd(`CMD_REF, 3'h0, 1'b0);
    idle(8); rd(`REG_REFCNT); chk(v, w + 4, "ref_burst");
  endtask
  task t_cke;
    m.setcke(1'b0); idle(24); m.cmd(`CMD_ACT, 3'h4, 1'b0);
    idle(8); chk(bo, 8'h00, "cke_low");
    m.setcke(1'b1); idle(24);
  endtask
  task t_strobe;
    m.strb(16'hA55A, 1'b1, 1'b0); chk(capt, 16'h005A, "lower_x16");
    m.strb(16'h3CC3, 1'b0, 1'b1); chk(capt, 16'h3C5A, "upper_x16");
    wr(`REG_CFG, 32'h0000A046);
    m.strb(16'hFFFF, 1'b0, 1'b1); chk(capt, 16'h3C5A, "upper_x8");
    m.strb(16'h1234, 1'b1, 1'b0); chk(capt, 16'h3C34, "lower_x8");
    wr(`REG_CFG, 32'h00002046);
    m.strb(16'h00A7, 1'b1, 1'b0); chk(capt[3:0], 4'h7, "lower_x4");
  endtask
  task complete_run;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    idle(16);
    i_nrst <= 1'b1;
    t_regs; t_lockout; t_pre; t_refresh; t_cke; t_strobe;
    complete_run;
  end
  // hang guard of about ten thousand cycles
  initial begin
    #400000;
    n_errors = n_errors + 1;
    complete_run;
  end
endmodule // tb_top
